/* File: pwc_pkg.sv */
package pwc_pkg;

    // ==========================================================
    // register map (byte offsets on the bus)
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] STATUS_CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] COUNT_VALUE_OFFSET = 12'h004;
    localparam logic [11:0] MODULO_LIMIT_OFFSET = 12'h008;

    // ==========================================================
    // status_control field layout
    localparam int unsigned MATCH_FLAG_BIT = 7;
    localparam int unsigned CLOCK_SOURCE_HI = 6;
    localparam int unsigned CLOCK_SOURCE_LO = 5;
    localparam int unsigned MATCH_IE_BIT = 4;
    localparam int unsigned PRESCALER_HI = 3;
    localparam int unsigned PRESCALER_LO = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MODULO_RESET = 8'h00;
    localparam logic [1:0] CLOCK_SOURCE_RESET = 2'h0;
    localparam logic [3:0] PRESCALER_RESET = 4'h0;
    localparam logic [3:0] PRESCALER_OFF = 4'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ==========================================================
    // clock sources and bus slave states
    typedef enum logic [1:0] {
        SRC_LOW_POWER = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_INTERNAL = 2'b10
    } pwc_source_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACCESS = 2'b01,
        BUS_ANSWER = 2'b10
    } pwc_bus_state_type;

    // ==========================================================
    // prescaler divide ratios, indexed by prescaler_select
    localparam int unsigned DIV_W = 18;
    localparam logic [17:0] DIV_TABLE_LOW [16] = '{
        18'h0_0001, 18'h0_0008, 18'h0_0020, 18'h0_0040,
        18'h0_0080, 18'h0_0100, 18'h0_0200, 18'h0_0400,
        18'h0_0001, 18'h0_0002, 18'h0_0004, 18'h0_000a,
        18'h0_0010, 18'h0_0064, 18'h0_01f4, 18'h0_03e8
    };
    localparam logic [17:0] DIV_TABLE_HIGH [16] = '{
        18'h0_0001, 18'h0_0400, 18'h0_0800, 18'h0_1000,
        18'h0_2000, 18'h0_4000, 18'h0_8000, 18'h1_0000,
        18'h0_03e8, 18'h0_07d0, 18'h0_1388, 18'h0_2710,
        18'h0_4e20, 18'h0_c350, 18'h1_86a0, 18'h3_0d40
    };
    localparam logic [17:0] DIV_ONE = 18'h0_0001;
    localparam logic [17:0] DIV_ZERO = 18'h0_0000;

endpackage

/* File: pwc_prescaler.sv */
module pwc_prescaler (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to the counter
    pwc_tick_if.presc link
);

    logic [pwc_pkg::DIV_W-1:0] div_sel;
    logic [pwc_pkg::DIV_W-1:0] div_count_reg;
    logic tick_reg;

    // ==========================================================
    // divide ratio lookup
    always_comb begin
        if (link.source_select_low) begin
            div_sel = pwc_pkg::DIV_TABLE_HIGH[link.prescaler_select];
        end else begin
            div_sel = pwc_pkg::DIV_TABLE_LOW[link.prescaler_select];
        end
    end

    // ==========================================================
    // divider: counts selected source edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count_reg <= pwc_pkg::DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (link.restart) begin
            div_count_reg <= pwc_pkg::DIV_ZERO;
            tick_reg <= 1'b0;
        end else if (link.prescaler_select == pwc_pkg::PRESCALER_OFF || link.freeze) begin
            tick_reg <= 1'b0;
        end else if (link.source_edge) begin
            if (div_count_reg >= div_sel - pwc_pkg::DIV_ONE) begin
                div_count_reg <= pwc_pkg::DIV_ZERO;
                tick_reg <= 1'b1;
            end else begin
                div_count_reg <= div_count_reg + pwc_pkg::DIV_ONE;
                tick_reg <= 1'b0;
            end
        end else begin
            tick_reg <= 1'b0;
        end
    end

    assign link.tick = tick_reg;

endmodule

/* File: pwc_tick_if.sv */
interface pwc_tick_if;
    logic source_select_low;
    logic [3:0] prescaler_select;
    logic source_edge;
    logic restart;
    logic freeze;
    logic tick;

    modport ctrl (
        output source_select_low,
        output prescaler_select,
        output source_edge,
        output restart,
        output freeze,
        input tick
    );

    modport presc (
        input source_select_low,
        input prescaler_select,
        input source_edge,
        input restart,
        input freeze,
        output tick
    );
endinterface

/* File: pwc_wakeup_counter.sv */
// Operation
// - flag bit 7 sets when count steps from modulo to zero
// - writing one clears flag and request
// - reset clears control fields, count, modulo
// - source select picks prescaler input clock
// - changed source select clears prescaler, counter
// - enabled flag drives interrupt request
// - prescaler code zero stops counting
// - changed prescaler select clears prescaler, counter
// - low source bit clear selects first ratio set
// - low source bit set selects second ratio set
// - count reads back, writes ignored
// - any modulo write clears prescaler, counter
// - match returns count to zero, sets flag
// - modulo zero flags every prescaler tick
// - debug mode freezes counting, resumes later
// - flag sets on modulo-to-zero step
// - deep stop leaves only low-power source
//
// Chosen here: the placing of the registers and the APB register port.
module pwc_wakeup_counter #(
    parameter int unsigned SYNC_STAGES = 3
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // counting clock sources
    input wire logic low_power_osc_clock,
    input wire logic external_reference_clock,
    input wire logic internal_reference_clock,
    // system mode
    input wire logic debug_active,
    input wire logic deep_stop,
    // interrupt request
    output logic match_irq
);

    // ==========================================================
    // declarations
    pwc_tick_if link ();

    pwc_pkg::pwc_bus_state_type bus_state_reg;
    pwc_pkg::pwc_bus_state_type bus_state_next;

    logic match_flag_reg;
    logic [1:0] clock_source_select_reg;
    logic match_interrupt_enable_reg;
    logic [3:0] prescaler_select_reg;
    logic [7:0] count_value_reg;
    logic [7:0] modulo_limit_reg;

    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic match_irq_reg;

    logic [2:0] src_raw;
    logic [2:0] src_level_reg;
    logic [2:0] src_rise;
    logic sel_rise;

    logic bus_commit;
    logic write_commit;
    logic hit_status;
    logic hit_count;
    logic hit_modulo;
    logic addr_mapped;
    logic wr_status;
    logic wr_modulo;
    logic [1:0] wr_source;
    logic [3:0] wr_prescaler;
    logic source_changed;
    logic prescaler_changed;
    logic restart;
    logic at_match;
    logic flag_set;
    logic flag_clear;
    logic match_flag_next;
    logic [7:0] status_view;
    logic [31:0] read_mux;
    logic tick_held_reg;
    logic count_step;

    // ==========================================================
    // source input synchronisers
    assign src_raw = {internal_reference_clock, external_reference_clock, low_power_osc_clock};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_src
            logic [SYNC_STAGES-1:0] sync_reg;

            // first stage feeds only the second
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_reg <= '0;
                end else begin
                    sync_reg <= {sync_reg[SYNC_STAGES-2:0], src_raw[gi]};
                end
            end

            // level accepted once the last two stages agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_level_reg[gi] <= 1'b0;
                end else if (sync_reg[SYNC_STAGES-1] == sync_reg[SYNC_STAGES-2]) begin
                    src_level_reg[gi] <= sync_reg[SYNC_STAGES-1];
                end
            end

            assign src_rise[gi] = (sync_reg[SYNC_STAGES-1] == sync_reg[SYNC_STAGES-2])
                                  && sync_reg[SYNC_STAGES-1] && !src_level_reg[gi];
        end
    endgenerate

    // ==========================================================
    // source selection
    always_comb begin
        case (clock_source_select_reg)
            pwc_pkg::SRC_LOW_POWER: begin
                sel_rise = src_rise[0];
            end
            pwc_pkg::SRC_EXTERNAL: begin
                sel_rise = src_rise[1] && !deep_stop;
            end
            default: begin
                sel_rise = src_rise[2] && !deep_stop;
            end
        endcase
    end

    // ==========================================================
    // bus slave sequencing
    always_comb begin
        case (bus_state_reg)
            pwc_pkg::BUS_IDLE: begin
                if (psel && !penable) begin
                    bus_state_next = pwc_pkg::BUS_ACCESS;
                end else begin
                    bus_state_next = pwc_pkg::BUS_IDLE;
                end
            end
            pwc_pkg::BUS_ACCESS: begin
                if (psel && penable) begin
                    bus_state_next = pwc_pkg::BUS_ANSWER;
                end else begin
                    bus_state_next = pwc_pkg::BUS_IDLE;
                end
            end
            pwc_pkg::BUS_ANSWER: begin
                bus_state_next = pwc_pkg::BUS_IDLE;
            end
            default: begin
                bus_state_next = pwc_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_reg <= pwc_pkg::BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ==========================================================
    // address decode and write strobes
    assign hit_status = (paddr == pwc_pkg::STATUS_CONTROL_OFFSET);
    assign hit_count = (paddr == pwc_pkg::COUNT_VALUE_OFFSET);
    assign hit_modulo = (paddr == pwc_pkg::MODULO_LIMIT_OFFSET);
    assign addr_mapped = hit_status || hit_count || hit_modulo;

    assign bus_commit = psel && penable && pready_reg;
    assign write_commit = bus_commit && pwrite && pstrb[0] && addr_mapped;
    assign wr_status = write_commit && hit_status;
    assign wr_modulo = write_commit && hit_modulo;

    assign wr_source = pwdata[pwc_pkg::CLOCK_SOURCE_HI:pwc_pkg::CLOCK_SOURCE_LO];
    assign wr_prescaler = pwdata[pwc_pkg::PRESCALER_HI:pwc_pkg::PRESCALER_LO];
    assign source_changed = wr_status && (wr_source != clock_source_select_reg);
    assign prescaler_changed = wr_status && (wr_prescaler != prescaler_select_reg);
    assign restart = source_changed || prescaler_changed || wr_modulo;

    // ==========================================================
    // answer generation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (bus_state_next == pwc_pkg::BUS_ANSWER) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !addr_mapped;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    assign status_view = {match_flag_reg, clock_source_select_reg,
                          match_interrupt_enable_reg, prescaler_select_reg};

    always_comb begin
        read_mux = pwc_pkg::READ_ZERO;
        if (hit_status) begin
            read_mux[7:0] = status_view;
        end else if (hit_count) begin
            read_mux[7:0] = count_value_reg;
        end else if (hit_modulo) begin
            read_mux[7:0] = modulo_limit_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= pwc_pkg::READ_ZERO;
        end else if (bus_state_next == pwc_pkg::BUS_ANSWER && !pwrite) begin
            prdata_reg <= read_mux;
        end else begin
            prdata_reg <= pwc_pkg::READ_ZERO;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_source_select_reg <= pwc_pkg::CLOCK_SOURCE_RESET;
            match_interrupt_enable_reg <= 1'b0;
            prescaler_select_reg <= pwc_pkg::PRESCALER_RESET;
        end else if (wr_status) begin
            clock_source_select_reg <= wr_source;
            match_interrupt_enable_reg <= pwdata[pwc_pkg::MATCH_IE_BIT];
            prescaler_select_reg <= wr_prescaler;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modulo_limit_reg <= pwc_pkg::MODULO_RESET;
        end else if (wr_modulo) begin
            modulo_limit_reg <= pwdata[7:0];
        end
    end

    // ==========================================================
    // prescaler link
    assign link.source_select_low = clock_source_select_reg[0];
    assign link.prescaler_select = prescaler_select_reg;
    assign link.source_edge = sel_rise;
    assign link.restart = restart;
    assign link.freeze = debug_active;

    pwc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .link(link)
    );

    // ==========================================================
    // freeze: a tick that lands as the freeze begins waits for release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_held_reg <= 1'b0;
        end else if (restart) begin
            tick_held_reg <= 1'b0;
        end else if (debug_active) begin
            tick_held_reg <= tick_held_reg || link.tick;
        end else begin
            tick_held_reg <= 1'b0;
        end
    end

    // restart cancels the step of the same cycle
    always_comb begin
        count_step = 1'b0;
        if (!restart && !debug_active) begin
            count_step = link.tick || tick_held_reg;
        end
    end

    // ==========================================================
    // main counter
    assign at_match = (count_value_reg == modulo_limit_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_reg <= pwc_pkg::COUNT_RESET;
        end else if (restart) begin
            count_value_reg <= pwc_pkg::COUNT_RESET;
        end else if (count_step) begin
            if (at_match) begin
                count_value_reg <= pwc_pkg::COUNT_RESET;
            end else begin
                count_value_reg <= count_value_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // match flag and interrupt
    assign flag_set = count_step && at_match;
    assign flag_clear = wr_status && pwdata[pwc_pkg::MATCH_FLAG_BIT];

    always_comb begin
        if (flag_set) begin
            match_flag_next = 1'b1;
        end else if (flag_clear) begin
            match_flag_next = 1'b0;
        end else begin
            match_flag_next = match_flag_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_flag_reg <= 1'b0;
            match_irq_reg <= 1'b0;
        end else begin
            match_flag_reg <= match_flag_next;
            match_irq_reg <= match_flag_next && (wr_status ? pwdata[pwc_pkg::MATCH_IE_BIT]
                                                           : match_interrupt_enable_reg);
        end
    end

    // ==========================================================
    // outputs
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign match_irq = match_irq_reg;

endmodule

/* File: pwc_wakeup_counter_props.sv */
module pwc_wakeup_counter_props #(
    parameter int unsigned SYNC_STAGES = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // sources and modes
    input wire logic low_power_osc_clock,
    input wire logic external_reference_clock,
    input wire logic internal_reference_clock,
    input wire logic debug_active,
    input wire logic deep_stop,
    // interrupt
    input wire logic match_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========
    // helpers
    wire done = psel && penable && pready;
    wire st = paddr == pwc_pkg::STATUS_CONTROL_OFFSET;
    wire mapped = st || paddr == pwc_pkg::COUNT_VALUE_OFFSET
        || paddr == pwc_pkg::MODULO_LIMIT_OFFSET;
    wire wst = done && pwrite && pstrb[0] && st;
    wire off_wr = wst && (pwdata[7] || !pwdata[4]);
    // ========
    // properties
    property p_wait_state;
        psel && !penable ##1 psel && penable |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_map;
        pslverr |-> pready && !mapped;
    endproperty
    property p_unmapped;
        done && !mapped |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_rd_width;
        done && !pwrite |-> prdata[31:8] == 24'h00_0000;
    endproperty
    property p_idle_data;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    property p_irq_off;
        wst && !pwdata[4] |=> !match_irq [*2];
    endproperty
    property p_irq_read;
        done && !pwrite && st |-> $past(match_irq) == (prdata[7] && prdata[4]);
    endproperty
    property p_irq_fall;
        $fell(match_irq) |-> $past(off_wr);
    endproperty
    property p_clear_frozen;
        wst && pwdata[7] && debug_active |=> !match_irq;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("late answer");
    a_ready_pulse: assert property (p_ready_pulse) else $error("long answer");
    a_err_map: assert property (p_err_map) else $error("bad error");
    a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
    a_rd_width: assert property (p_rd_width) else $error("wide read");
    a_idle_data: assert property (p_idle_data) else $error("idle data");
    a_irq_off: assert property (p_irq_off) else $error("irq disabled");
    a_irq_read: assert property (p_irq_read) else $error("irq vs flag");
    a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
    a_clear_frozen: assert property (p_clear_frozen) else $error("no clear");
    c_clear: cover property (wst && pwdata[7]);
    c_irq: cover property ($rose(match_irq));
    c_err: cover property (pslverr);
endmodule

bind pwc_wakeup_counter pwc_wakeup_counter_props #(.SYNC_STAGES(SYNC_STAGES)) chk_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .low_power_osc_clock, .external_reference_clock,
    .internal_reference_clock, .debug_active, .deep_stop, .match_irq
);

/* File: pwc_wakeup_counter_test.sv */
module pwc_wakeup_counter_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] SC = pwc_pkg::STATUS_CONTROL_OFFSET;
    localparam logic [11:0] CV = pwc_pkg::COUNT_VALUE_OFFSET;
    localparam logic [11:0] ML = pwc_pkg::MODULO_LIMIT_OFFSET;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, match_irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] src_pin;
    logic debug_active, deep_stop;
    logic [7:0] d;
    logic [7:0] cfg [3] = '{8'h28, 8'h4b, 8'h68};
    int n_fail, n_checks, sp, r;
    int cyc = 0;
    int m_cnt, m_mod, m_flag, m_ie, m_src, m_ps, m_pre;
    int lo [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
    int hi [16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
        1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

    pwc_wakeup_counter dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .low_power_osc_clock(src_pin[0]), .external_reference_clock(src_pin[1]),
        .internal_reference_clock(src_pin[2]), .debug_active(debug_active),
        .deep_stop(deep_stop), .match_irq(match_irq)
    );

    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end

    // ========
    // checking
    task automatic chk(logic [31:0] g, logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ========
    // bus and source drivers
    task automatic apb(logic w, logic [11:0] a, logic [31:0] wd, logic [3:0] s);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic m_edge();
        r = m_src[0] ? hi[m_ps] : lo[m_ps];
        if (r > 0 && ++m_pre >= r) begin
            m_pre = 0;
            m_flag |= m_cnt == m_mod;
            m_cnt = m_cnt == m_mod ? 0 : m_cnt + 1;
        end
    endtask

    // edges last 3 cycles high and low, then the tick pipeline settles
    task automatic pulse(int pin, int n);
        repeat (n) begin
            src_pin[pin] <= 1'b1;
            repeat (3) @(posedge pclk);
            src_pin[pin] <= 1'b0;
            repeat (3) @(posedge pclk);
            if (pin == sp && !debug_active && !(deep_stop && pin != 0))
                m_edge();
        end
        repeat (8) @(posedge pclk);
    endtask

    task automatic wr(logic [11:0] a, logic [7:0] v);
        apb(1, a, {24'h00_0000, v}, 4'hf);
        if (a == SC) begin
            if (v[7])
                m_flag = 0;
            if (v[6:5] != m_src || v[3:0] != m_ps) begin
                m_cnt = 0;
                m_pre = 0;
            end
            m_src = v[6:5];
            m_ie = v[4];
            m_ps = v[3:0];
        end else if (a == ML) begin
            m_mod = v;
            m_cnt = 0;
            m_pre = 0;
        end
    endtask

    task automatic check_all();
        apb(0, SC, 32'h0, 4'hf);
        chk(rd, {24'h0, m_flag[0], m_src[1:0], m_ie[0], m_ps[3:0]});
        chk({31'h0, match_irq}, {31'h0, m_flag[0] & m_ie[0]});
        apb(0, CV, 32'h0, 4'hf);
        chk(rd, m_cnt);
        apb(0, ML, 32'h0, 4'hf);
        chk(rd, m_mod);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic do_reset();
        presetn <= 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        m_cnt = 0;
        m_mod = 0;
        m_flag = 0;
        m_ie = 0;
        m_src = 0;
        m_ps = 0;
        m_pre = 0;
    endtask

    // ========
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, src_pin} = '0;
        debug_active = 0;
        deep_stop = 0;
        presetn = 0;
        n_fail = 0;
        n_checks = 0;
        sp = 0;
        void'($urandom(32'ha487));
        @(posedge pclk);
        do_reset();
        check_all();
        for (int i = 0; i < 19; i++) begin
            wr(ML, 8'($urandom % 3));
            pulse(sp, $urandom % 3);
            apb(0, CV, 32'h0, 4'hf);
            chk(rd, m_cnt);
            debug_active <= $urandom % 3 == 0;
            deep_stop <= $urandom % 2 == 0;
            d = i < 16 ? 8'(i) : cfg[i - 16];
            d[4] = 1'($urandom);
            wr(SC, d);
            sp = m_src > 2 ? 2 : m_src;
            r = m_src[0] ? hi[m_ps] : lo[m_ps];
            pulse(sp, r ? r * (1 + $urandom % 2) - $urandom % 2 : 5);
            pulse((sp + 1) % 3, 3);
            check_all();
            d[7] = 1'($urandom);
            wr(SC, d);
            debug_active <= 0;
            pulse(sp, 1);
            check_all();
        end
        wr(CV, 8'($urandom));
        apb(1, ML, 32'h0000_0055, 4'h0);
        apb(0, 12'h00c, 32'h0, 4'hf);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1, 12'h00c, 32'h0000_00ff, 4'hf);
        check_all();
        do_reset();
        check_all();
        give_verdict();
    end
endmodule
